//--- design/pwr_clk_pkg.sv
package pwr_clk_pkg;
  // Register byte offsets on the APB.
  localparam logic [11:0] OSC_CTRL_OFF = 12'h000;
  localparam logic [11:0] PERIPH_IDLE_OFF = 12'h004;
  localparam logic [11:0] POWER_STAT_OFF = 12'h008;
  localparam logic [11:0] CLK_SWITCH_OFF = 12'h00c;
  // Field positions in the oscillator control register.
  localparam int SLEEP_SEL_POS = 4;
  localparam int DIV_LO_POS = 19;
  localparam int DIV_HI_POS = 20;
  // Reset values.
  localparam logic [1:0] DIV_RESET = 2'h0;
  localparam logic SLEEP_SEL_RESET = 1'b0;
  // Start-up delays in ns, and the 50 MHz clock period.
  localparam int CLK_PERIOD_NS = 20;
  localparam int OSC_START_NS = 1000;
  localparam int PLL_LOCK_NS = 2000;
  localparam int OSC_START_CYC = (OSC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PLL_LOCK_CYC = (PLL_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NUM_PERIPH = 8;
  typedef enum logic [1:0] {RUN, IDLE, SLEEP} pmode_e;
endpackage : pwr_clk_pkg

//--- design/pb_divider.sv
`timescale 1ns/10ps
`default_nettype none
// Divides the system clock into a one-cycle enable. While running, a new ratio is
// only adopted at the end of a full period, so the enable never glitches.
module pb_divider (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [1:0] div_sel,
  output logic tick
);
  logic [2:0] cnt_r;
  logic [1:0] cur_r;
  wire [2:0] limit = (3'h1 << cur_r) - 3'h1; // R15
  wire wrap = (cnt_r >= limit);

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= 3'h0;
      cur_r <= 2'h0;
    end else if (run) begin
      cnt_r <= wrap ? 3'h0 : cnt_r + 3'h1;
      if (wrap) begin
        cur_r <= div_sel; // R15
      end
    end else begin
      cnt_r <= 3'h0;
      cur_r <= div_sel;
    end
  end

  assign tick = run & wrap; // R9

  a_tick_gap: assert property (@(posedge clk) disable iff (rst)
    tick && div_sel == 2'h3 |=> !tick [*7]) // R9
    else $error("divide-by-8 tick spacing wrong");
endmodule : pb_divider
`default_nettype wire

//--- design/power_mode_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
// Function
// R1: Sleep wakes on enabled sleep-capable interrupt above CPU priority.
// R2: Sleep also ends on any reset or watchdog time-out.
// R3: Low-priority Sleep wake keeps CPU halted, restarts bus clock, enters Idle.
// R4: Idle halts the CPU while the system clock keeps running.
// R5: Peripherals with stop-in-idle set halt in Idle; others run.
// R6: Wait with sleep-select clear enters Idle.
// R7: Idle ends on enabled interrupt above CPU priority only.
// R8: Idle also ends on any reset or watchdog time-out.
// R9: Bus clock is system clock divided by 1, 2, 4 or 8 from field 20:19.
// R10: Divider affects bus-clock peripherals only, not system-clock blocks.
// R11: CPU peripheral read completes at the next bus clock edge.
// R12: Switching to a stopped crystal or PLL source applies start-up delays.
// R13: Software should pick the slowest adequate bus clock.
// R14: Wait with sleep-select set enters Sleep, stopping CPU and bus clock.
// R15: Divider codes 00..11 mean 1:1..1:8; changes apply glitch-free.
module power_mode_ctrl
  import pwr_clk_pkg::*;
#(
  parameter int NPER = NUM_PERIPH,
  parameter int PRIO_W = 3
) (
  // Clock and reset.
  input wire logic REF_CLK,
  input wire logic RESET,
  // APB slave.
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // CPU and interrupt controller.
  input wire logic WAIT_EXEC,
  input wire logic [PRIO_W-1:0] CPU_PRIO,
  input wire logic IRQ_VALID,
  input wire logic IRQ_SLEEP_OK,
  input wire logic [PRIO_W-1:0] IRQ_PRIO,
  input wire logic WDT_TIMEOUT,
  input wire logic DEV_RESET,
  // Peripheral read handshake.
  input wire logic PB_READ_REQ,
  output logic PB_READ_DONE,
  // Clock source status.
  input wire logic SRC_IS_CRYSTAL,
  input wire logic SRC_USES_PLL,
  // Clock outputs and enables.
  output logic CPU_HALT,
  output logic SYS_CLK_EN,
  output logic PB_CLK_EN,
  output logic [NPER-1:0] PERIPH_CLK_EN,
  output logic CLK_SWITCH_BUSY,
  output logic [1:0] POWER_MODE
);
  initial begin
    if (NPER < 1 || NPER > 32) $error("NPER must be 1 to 32");
    if (PRIO_W < 1 || PRIO_W > 8) $error("PRIO_W must be 1 to 8");
  end

  pmode_e mode_r, mode_nxt;
  logic sleep_sel_r;
  logic [1:0] pb_div_r;
  logic [NPER-1:0] stop_idle_r;
  logic src_on_r;
  logic [15:0] delay_r, delay_nxt;
  logic rd_pend_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pb_tick;

  // Bus decode.
  wire setup = PSEL & ~PENABLE;
  // Writes land at the access edge where PREADY is seen high, as the master expects.
  wire access = PSEL & PENABLE & pready_r;
  wire wr = access & PWRITE;
  wire hit_osc = (PADDR == OSC_CTRL_OFF);
  wire hit_idle = (PADDR == PERIPH_IDLE_OFF);
  wire hit_stat = (PADDR == POWER_STAT_OFF);
  wire hit_sw = (PADDR == CLK_SWITCH_OFF);
  wire hit_any = hit_osc | hit_idle | hit_stat | hit_sw;

  // Wake conditions: reset forms and watchdog override everything.
  wire hard_wake = DEV_RESET | WDT_TIMEOUT;
  wire prio_above = IRQ_PRIO > CPU_PRIO;
  wire sleep_irq = IRQ_VALID & IRQ_SLEEP_OK;

  function automatic logic [31:0] pad(input logic [31:0] v);
    pad = v;
  endfunction : pad

  wire [31:0] osc_word = pad({11'h0, pb_div_r, 14'h0, sleep_sel_r, 4'h0});
  wire [31:0] stat_word = pad({14'h0, CLK_SWITCH_BUSY, 13'h0, src_on_r, 1'b0, mode_r});
  wire [31:0] idle_word = pad({{(32 - NPER){1'b0}}, stop_idle_r});
  wire [31:0] rd_mux = hit_osc ? osc_word : hit_idle ? idle_word :
                       hit_stat ? stat_word : 32'h0;

  // Writes to the clock switch register with bit 0 set request a new source; the written
  // running flag decides, since the stored one still describes the old source.
  wire sw_req = wr & hit_sw & PWDATA[0];
  wire [15:0] sw_delay = (!PWDATA[1] && (SRC_IS_CRYSTAL || SRC_USES_PLL)) ?
    16'((SRC_IS_CRYSTAL ? OSC_START_CYC : 0) + (SRC_USES_PLL ? PLL_LOCK_CYC : 0)) : 16'h0;

  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      RUN: begin
        if (WAIT_EXEC && !hard_wake) begin
          mode_nxt = sleep_sel_r ? SLEEP : IDLE; // R6 R14
        end
      end
      IDLE: begin
        if (hard_wake || (IRQ_VALID && prio_above)) begin
          mode_nxt = RUN; // R7 R8
        end
      end
      SLEEP: begin
        if (hard_wake || (sleep_irq && prio_above)) begin
          mode_nxt = RUN; // R1 R2
        end else if (sleep_irq) begin
          mode_nxt = IDLE; // R3
        end
      end
      default: mode_nxt = RUN;
    endcase
  end

  always_comb begin
    delay_nxt = delay_r;
    if (sw_req) begin
      delay_nxt = sw_delay; // R12
    end else if (delay_r != 16'h0) begin
      delay_nxt = delay_r - 16'h1;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      mode_r <= RUN;
      delay_r <= 16'h0;
    end else begin
      mode_r <= mode_nxt;
      delay_r <= delay_nxt;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      sleep_sel_r <= SLEEP_SEL_RESET;
      pb_div_r <= DIV_RESET;
      stop_idle_r <= '0;
      src_on_r <= 1'b1;
    end else begin
      if (wr && hit_osc) begin
        sleep_sel_r <= PWDATA[SLEEP_SEL_POS];
        pb_div_r <= PWDATA[DIV_HI_POS:DIV_LO_POS]; // R9
      end
      if (wr && hit_idle) begin
        stop_idle_r <= PWDATA[NPER-1:0];
      end
      if (wr && hit_sw) begin
        src_on_r <= PWDATA[1];
      end
    end
  end

  // APB answers one cycle after setup, so no access has a wait state.
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      pready_r <= 1'b0;
      prdata_r <= 32'h0;
      PSLVERR <= 1'b0;
    end else begin
      pready_r <= setup;
      PSLVERR <= setup & ~hit_any;
      prdata_r <= (setup && !PWRITE) ? rd_mux : 32'h0;
    end
  end
  assign PREADY = pready_r;
  assign PRDATA = prdata_r;

  // The divider only restarts from zero after Sleep, so the first bus edge
  // after wake lands a full period later.
  wire pb_run = (mode_r != SLEEP); // R14 R3
  pb_divider u_div (
    .clk(REF_CLK),
    .rst(RESET),
    .run(pb_run),
    .div_sel(pb_div_r),
    .tick(pb_tick)
  );

  // A peripheral read is held until the next bus clock edge.
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      rd_pend_r <= 1'b0;
      PB_READ_DONE <= 1'b0;
    end else begin
      PB_READ_DONE <= (PB_READ_REQ | rd_pend_r) & pb_tick; // R11
      rd_pend_r <= (PB_READ_REQ | rd_pend_r) & ~pb_tick;
    end
  end

  // Gating of bus-clock peripherals; system-clock blocks see SYS_CLK_EN only.
  genvar g;
  generate
    for (g = 0; g < NPER; g++) begin : g_per
      always_ff @(posedge REF_CLK) begin
        if (RESET) begin
          PERIPH_CLK_EN[g] <= 1'b0;
        end else begin
          PERIPH_CLK_EN[g] <= pb_tick & ~(mode_nxt == IDLE && stop_idle_r[g]); // R5 R10
        end
      end
    end
  endgenerate

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      CPU_HALT <= 1'b0;
      SYS_CLK_EN <= 1'b1;
      PB_CLK_EN <= 1'b0;
      CLK_SWITCH_BUSY <= 1'b0;
      POWER_MODE <= 2'h0;
    end else begin
      CPU_HALT <= (mode_nxt != RUN) | (delay_nxt != 16'h0); // R4
      SYS_CLK_EN <= (mode_nxt != SLEEP); // R4
      PB_CLK_EN <= pb_tick; // R10
      CLK_SWITCH_BUSY <= (delay_nxt != 16'h0); // R12
      POWER_MODE <= mode_nxt;
    end
  end

  a_idle_entry: assert property (@(posedge REF_CLK) disable iff (RESET)
    mode_r == RUN && WAIT_EXEC && !hard_wake && !sleep_sel_r
      |=> mode_r == IDLE && CPU_HALT && SYS_CLK_EN) // R6
    else $error("wait with sleep-select clear did not enter Idle");
  a_sleep_entry: assert property (@(posedge REF_CLK) disable iff (RESET)
    mode_r == RUN && WAIT_EXEC && !hard_wake && sleep_sel_r
      |=> mode_r == SLEEP && !SYS_CLK_EN ##1 !PB_CLK_EN) // R14
    else $error("wait with sleep-select set did not enter Sleep");
  a_sleep_wake: assert property (@(posedge REF_CLK) disable iff (RESET)
    mode_r == SLEEP && sleep_irq && prio_above |=> mode_r == RUN && !CPU_HALT) // R1
    else $error("high priority interrupt did not wake from Sleep");
  a_sleep_hard: assert property (@(posedge REF_CLK) disable iff (RESET)
    mode_r == SLEEP && hard_wake |=> mode_r == RUN) // R2
    else $error("reset or watchdog did not end Sleep");
  a_sleep_low: assert property (@(posedge REF_CLK) disable iff (RESET)
    mode_r == SLEEP && sleep_irq && !prio_above && !hard_wake
      |=> mode_r == IDLE && CPU_HALT) // R3
    else $error("low priority wake did not move to Idle");
  a_idle_stay: assert property (@(posedge REF_CLK) disable iff (RESET)
    mode_r == IDLE && IRQ_VALID && !prio_above && !hard_wake |=> mode_r == IDLE) // R7
    else $error("low priority interrupt left Idle");
  a_idle_exit: assert property (@(posedge REF_CLK) disable iff (RESET)
    mode_r == IDLE && (hard_wake || (IRQ_VALID && prio_above)) |=> mode_r == RUN) // R7 R8
    else $error("Idle did not end on wake event");
  a_idle_stop: assert property (@(posedge REF_CLK) disable iff (RESET)
    mode_r == IDLE && mode_nxt == IDLE && stop_idle_r[0] |=> !PERIPH_CLK_EN[0]) // R5
    else $error("stopped peripheral clocked in Idle");
  a_read_done: assert property (@(posedge REF_CLK) disable iff (RESET)
    PB_READ_REQ && pb_tick |=> PB_READ_DONE) // R11
    else $error("peripheral read not completed at bus edge");
  a_switch_delay: assert property (@(posedge REF_CLK) disable iff (RESET)
    sw_req && sw_delay > 16'h1 |=> CLK_SWITCH_BUSY ##1 CLK_SWITCH_BUSY) // R12
    else $error("start-up delay not applied");
endmodule : power_mode_ctrl
`default_nettype wire

//--- verif/irq_src_model.sv
`timescale 1ns/10ps
`default_nettype none
// Interrupt controller stand-in: a request stays pending until dropped.
module irq_src_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Commands from the bench.
  input wire logic raise,
  input wire logic drop,
  input wire logic [2:0] prio,
  input wire logic sleep_ok,
  // Request lines.
  output logic irq_valid,
  output logic [2:0] irq_prio,
  output logic irq_sleep_ok
);
  // With no request pending the priority toggles, so a stale value is never trusted.
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_valid <= 1'b0;
      irq_prio <= 3'h0;
      irq_sleep_ok <= 1'b0;
    end else if (drop) begin
      irq_valid <= 1'b0;
    end else if (raise) begin
      irq_valid <= 1'b1;
      irq_prio <= prio;
      irq_sleep_ok <= sleep_ok;
    end else if (!irq_valid) begin
      irq_prio <= ~irq_prio;
    end
  end
endmodule : irq_src_model
`default_nettype wire

//--- verif/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  import pwr_clk_pkg::*;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic wait_exec = 1'b0, raise = 1'b0, drop = 1'b0, rq_sok = 1'b0, wdt = 1'b0;
  logic dev_rst = 1'b0, rd_req = 1'b0, crystal = 1'b0, pll = 1'b0, err;
  logic [2:0] cpu_prio = 3'h3, rq_prio = 3'h0, irq_prio;
  logic pready, pslverr, rd_done, halt, sysen, pben, busy, irq_valid, irq_sok;
  logic [7:0] pclken, acc;
  logic [1:0] mode, dv = 2'h0;
  int failures = 0, checks_done = 0, cycles = 0, n;
  always #10 clk = ~clk;
  power_mode_ctrl uut (.REF_CLK(clk), .RESET(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .WAIT_EXEC(wait_exec), .CPU_PRIO(cpu_prio), .IRQ_VALID(irq_valid),
    .IRQ_SLEEP_OK(irq_sok), .IRQ_PRIO(irq_prio), .WDT_TIMEOUT(wdt), .DEV_RESET(dev_rst),
    .PB_READ_REQ(rd_req), .PB_READ_DONE(rd_done), .SRC_IS_CRYSTAL(crystal),
    .SRC_USES_PLL(pll), .CPU_HALT(halt), .SYS_CLK_EN(sysen), .PB_CLK_EN(pben),
    .PERIPH_CLK_EN(pclken), .CLK_SWITCH_BUSY(busy), .POWER_MODE(mode));
  irq_src_model irq (.clk(clk), .rst(rst), .raise(raise), .drop(drop), .prio(rq_prio),
    .sleep_ok(rq_sok), .irq_valid(irq_valid), .irq_prio(irq_prio), .irq_sleep_ok(irq_sok));
  task end_of_test;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // Request is held until PREADY is sampled high; data is taken at that edge.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int g;
    g = 0;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && g < 20) begin
      @(posedge clk);
      g++;
    end
    check("pready", {31'h0, pready}, 32'h1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task run(input int c);
    acc = 8'h00; n = 0;
    repeat (c) begin
      @(posedge clk);
      acc |= pclken;
      n += int'(pben);
    end
  endtask : run
  task irq_req(input logic [2:0] p, input logic s);
    @(posedge clk); drop <= 1'b1;
    @(posedge clk); drop <= 1'b0; raise <= 1'b1; rq_prio <= p; rq_sok <= s;
    @(posedge clk); raise <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : irq_req
  task enter(input logic s);
    apb(1'b1, OSC_CTRL_OFF, {11'h0, dv, 14'h0, s, 4'h0});
    @(posedge clk); wait_exec <= 1'b1;
    @(posedge clk); wait_exec <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : enter
  always @(posedge clk) begin
    cycles++;
    if (cycles > 5000) begin
      failures++;
      end_of_test();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check("mode", mode, 0);
    check("sysen", sysen, 1);
    apb(1'b0, OSC_CTRL_OFF, 32'h0);
    check("osc", q, 32'h0);
    // The slowest ratio is kept last, as software should choose it when it suffices.
    for (int k = 0; k < 4; k++) begin
      dv = 2'(k);
      apb(1'b1, OSC_CTRL_OFF, {11'h0, dv, 19'h0});
      run(16);
      run(64);
      check("pb pulses", n, 64 >> k);
    end
    for (int k = 0; k < 8; k++) begin
      repeat (k) @(posedge clk);
      rd_req <= 1'b1;
      @(posedge clk); rd_req <= 1'b0; n = 0;
      while (rd_done !== 1'b1 && n < 20) begin
        @(posedge clk);
        n++;
      end
      check("rd latency", (n >= 1 && n <= 8), 1);
    end
    dv = 2'h0;
    apb(1'b1, PERIPH_IDLE_OFF, 32'h0f);
    enter(1'b0);
    check("idle mode", {halt, sysen, mode}, 4'hd);
    apb(1'b0, POWER_STAT_OFF, 32'h0);
    check("stat", q[1:0], 1);
    run(16);
    check("idle gating", acc, 8'hf0);
    irq_req(3'h3, 1'b1);
    check("equal prio", mode, 1);
    irq_req(3'h5, 1'b0);
    check("idle exit", {halt, busy, mode}, 0);
    run(16);
    check("run gating", acc, 8'hff);
    irq_req(3'h0, 1'b0);
    enter(1'b1);
    check("sleep", {halt, sysen, mode}, 4'ha);
    run(16);
    check("sleep pb", n, 0);
    irq_req(3'h5, 1'b1);
    check("sleep wake", mode, 0);
    irq_req(3'h0, 1'b0);
    enter(1'b1);
    irq_req(3'h5, 1'b0);
    check("not sleep capable", mode, 2);
    irq_req(3'h2, 1'b1);
    check("low wake", {halt, mode}, 3'h5);
    run(16);
    check("low wake pb", n, 16);
    irq_req(3'h6, 1'b1);
    irq_req(3'h0, 1'b0);
    for (int ev = 0; ev < 4; ev++) begin
      enter(ev[0]);
      @(posedge clk); wdt <= ev[1]; dev_rst <= !ev[1];
      @(posedge clk); wdt <= 1'b0; dev_rst <= 1'b0;
      repeat (3) @(posedge clk);
      check("hard wake", mode, 0);
    end
    crystal <= 1'b1;
    apb(1'b1, CLK_SWITCH_OFF, 32'h1);
    @(posedge clk);
    check("switch halt", {halt, busy}, 2'h3);
    n = 0;
    while (busy === 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    check("osc delay", (n >= OSC_START_CYC - 3 && n <= OSC_START_CYC + 1), 1);
    apb(1'b1, CLK_SWITCH_OFF, 32'h3);
    @(posedge clk);
    check("no delay", busy, 0);
    apb(1'b0, 12'h010, 32'h0);
    check("unmapped err", err, 1);
    check("unmapped", q, 32'h0);
    end_of_test();
  end
endmodule : tb
`default_nettype wire
